// File: design/lcd_cmd_decoder.sv
// Purpose: Host command decoder for display switch, cursor and memory write.
// Assumes: Host bytes come from logic on REF_CLK; APB answers with no wait.
// Notes:   An APB write in the same cycle as a host byte wins for that field.
// Notes on behaviour
// R1: Code 58h clears display enable bit 0; 59h sets it.
// R2: Display switch parameter loads attribute: flash, first, second/fourth, third block fields.
// R3: Attribute 56h gives 2 Hz cursor flash and all four blocks on.
// R4: Code 46h: first parameter to low address, second to high address.
// R5: Code 5Dh first parameter bits 3-0 hold cursor width minus one.
// R6: Second shape parameter: height minus one in bits 3-0, block cursor bit 7.
// R7: Codes 4Ch-4Fh set shift direction, no parameter; 4Ch right, 4Fh down.
// R8: Code 42h writes each parameter at the cursor, then advances the cursor.
// R9: Host clears text layer to 20h and graphics layer to 00h.
// R10: Code 44h loads block start addresses and line counts.
// R11: Host marks each byte; parameters go to successive slots of last command.
// R12: Host keeps display off until memory and cursor setup is done.
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module lcd_cmd_decoder (
  input  wire logic                  REF_CLK,      // 20 MHz system clock
  input  wire logic                  RSTN,         // Async reset, active low
  input  wire logic                  HOST_VALID,   // Host byte offered
  output logic                       HOST_READY,   // Host byte taken when valid
  input  wire lcd_pkg::lcd_hostbyte_t HOST_BYTE,   // Command flag and byte
  output logic                       MEM_VALID,    // Memory write word ready
  input  wire logic                  MEM_READY,    // Memory accepts word
  output lcd_pkg::lcd_memwr_t        MEM_WORD,     // Address and data
  input  wire logic                  PSEL,         // APB select
  input  wire logic                  PENABLE,      // APB access phase
  input  wire logic                  PWRITE,       // APB write
  input  wire logic [7:0]            PADDR,        // APB byte address
  input  wire logic [31:0]           PWDATA,       // APB write data
  output logic [31:0]                PRDATA,       // APB read data
  output logic                       PREADY,       // APB ready
  output logic                       PSLVERR,      // APB error, unmapped or misaligned
  output logic                       DISP_ON,      // Display enable
  output lcd_pkg::lcd_attr_t         BLOCK_ATTR,   // Flash and block fields
  output logic [15:0]                CURSOR_ADDR,  // Cursor address
  output logic [3:0]                 CURSOR_WIDTH, // Width minus one
  output logic [3:0]                 CURSOR_HEIGHT,// Height minus one
  output logic                       CURSOR_BLOCK, // Block cursor shape
  output logic [1:0]                 SHIFT_DIR     // Auto shift direction
);

  lcd_pkg::lcd_state_t s_r;
  lcd_pkg::lcd_state_t s_nxt;
  logic                host_take;
  logic                is_param;
  logic                buf_in_ready;
  logic                mem_push;
  logic [15:0]         csr_now;
  logic [15:0]         csr_adv;
  logic [5:0]          idx;
  logic                aligned;
  logic                apb_setup;
  logic                apb_wr;
  logic                in_blk;
  logic [3:0]          blk_sel;
  logic [31:0]         rd_val;
  logic                rd_ok;

  // ==========================================================================
  // Host byte handshake
  // After a memory write command every byte, command or parameter, needs buffer room; otherwise never stall
  assign is_param   = !HOST_BYTE.is_cmd && s_r.cmd_seen;
  assign HOST_READY = (s_r.cmd_seen && s_r.cmd == lcd_pkg::MEMORY_WRITE_CMD) ? buf_in_ready : 1'b1;
  assign host_take  = HOST_VALID && HOST_READY;
  assign mem_push   = host_take && is_param && s_r.cmd == lcd_pkg::MEMORY_WRITE_CMD;
  assign csr_now    = {s_r.csr_hi, s_r.csr_lo};

  // R8 cursor step
  always_comb begin
    case (s_r.shift_dir[1:0])
      lcd_pkg::SHIFT_RIGHT: csr_adv = csr_now + 16'h0001;
      lcd_pkg::SHIFT_LEFT:  csr_adv = csr_now - 16'h0001;
      lcd_pkg::SHIFT_UP:    csr_adv = csr_now - s_r.pitch;
      default:              csr_adv = csr_now + s_r.pitch;
    endcase
  end

  // ==========================================================================
  // APB decode; zero wait, so PREADY is always high
  assign idx       = PADDR[7:2];
  assign aligned   = (PADDR[1:0] == 2'h0);
  assign apb_setup = PSEL && !PENABLE;
  assign apb_wr    = PSEL && PENABLE && PWRITE && !s_r.slverr;
  assign in_blk    = (idx >= lcd_pkg::IDX_BLOCK_SETUP_FIRST) &&
                     (idx < lcd_pkg::IDX_BLOCK_SETUP_FIRST + 6'(lcd_pkg::BLOCK_SETUP_PARAMS));
  assign blk_sel   = 4'(idx - lcd_pkg::IDX_BLOCK_SETUP_FIRST);
  assign PREADY    = 1'b1;
  assign PRDATA    = s_r.prdata;
  assign PSLVERR   = s_r.slverr;

  // Read mux; unused upper bits read as zero
  always_comb begin
    rd_val = '0;
    rd_ok  = aligned;
    if (in_blk) begin
      rd_val = 32'(s_r.blk[blk_sel]);
    end else begin
      case (idx)
        lcd_pkg::IDX_DISPLAY_ENABLE_CTRL: rd_val = 32'(s_r.disp_ctrl);
        lcd_pkg::IDX_BLOCK_CURSOR_ATTR:   rd_val = 32'(s_r.attr);
        lcd_pkg::IDX_CURSOR_WIDTH:        rd_val = 32'(s_r.csr_width);
        lcd_pkg::IDX_CURSOR_HEIGHT_SHAPE: rd_val = 32'(s_r.csr_hshape);
        lcd_pkg::IDX_CURSOR_SHIFT_DIR:    rd_val = 32'(s_r.shift_dir);
        lcd_pkg::IDX_CURSOR_ADDRESS_LOW:  rd_val = 32'(s_r.csr_lo);
        lcd_pkg::IDX_CURSOR_ADDRESS_HIGH: rd_val = 32'(s_r.csr_hi);
        lcd_pkg::IDX_DECODER_STATUS:      rd_val = 32'({MEM_VALID, buf_in_ready, s_r.cmd_seen, s_r.pidx, s_r.cmd});
        lcd_pkg::IDX_LINE_PITCH:          rd_val = 32'(s_r.pitch);
        default:                          rd_ok  = 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Command interpreter and register file
  always_comb begin
    s_nxt = s_r;
    if (host_take && HOST_BYTE.is_cmd) begin
      // R11 new command resets slot
      s_nxt.cmd      = HOST_BYTE.data;
      s_nxt.cmd_seen = 1'b1;
      s_nxt.pidx     = '0;
      case (HOST_BYTE.data)
        // R1 display enable
        lcd_pkg::DISPLAY_SWITCH_CMD_OFF: s_nxt.disp_ctrl[lcd_pkg::DISP_EN_BIT] = 1'b0;
        lcd_pkg::DISPLAY_SWITCH_CMD_ON:  s_nxt.disp_ctrl[lcd_pkg::DISP_EN_BIT] = 1'b1;
        // R7 direction from code alone
        lcd_pkg::CURSOR_DIR_CMD_RIGHT:   s_nxt.shift_dir = 8'(lcd_pkg::SHIFT_RIGHT);
        lcd_pkg::CURSOR_DIR_CMD_LEFT:    s_nxt.shift_dir = 8'(lcd_pkg::SHIFT_LEFT);
        lcd_pkg::CURSOR_DIR_CMD_UP:      s_nxt.shift_dir = 8'(lcd_pkg::SHIFT_UP);
        lcd_pkg::CURSOR_DIR_CMD_DOWN:    s_nxt.shift_dir = 8'(lcd_pkg::SHIFT_DOWN);
        default: ;
      endcase
    end else if (host_take && is_param) begin
      // R11 successive slots; saturates so a long stream never wraps
      if (s_r.pidx != lcd_pkg::PIDX_LAST) begin
        s_nxt.pidx = s_r.pidx + 4'h1;
      end
      case (s_r.cmd)
        lcd_pkg::DISPLAY_SWITCH_CMD_OFF, lcd_pkg::DISPLAY_SWITCH_CMD_ON: begin
          // R2 attribute load; R3 follows from the field layout
          if (s_r.pidx == 4'h0) begin
            s_nxt.attr = HOST_BYTE.data;
          end
        end
        lcd_pkg::CURSOR_ADDRESS_LOAD_CMD: begin
          // R4 low then high
          if (s_r.pidx == 4'h0) begin
            s_nxt.csr_lo = HOST_BYTE.data;
          end else if (s_r.pidx == 4'h1) begin
            s_nxt.csr_hi = HOST_BYTE.data;
          end
        end
        lcd_pkg::CURSOR_SHAPE_CMD: begin
          // R5 width, R6 height and shape
          if (s_r.pidx == 4'h0) begin
            s_nxt.csr_width = {4'h0, HOST_BYTE.data[3:0]};
          end else if (s_r.pidx == 4'h1) begin
            s_nxt.csr_hshape = {HOST_BYTE.data[lcd_pkg::SHAPE_BIT], 3'h0, HOST_BYTE.data[3:0]};
          end
        end
        lcd_pkg::BLOCK_SETUP_CMD: begin
          // R10 block start addresses and line counts
          if (s_r.pidx < 4'(lcd_pkg::BLOCK_SETUP_PARAMS)) begin
            s_nxt.blk[s_r.pidx] = HOST_BYTE.data;
          end
        end
        lcd_pkg::MEMORY_WRITE_CMD: begin
          // R8 byte already pushed at csr_now; step afterwards
          s_nxt.csr_lo = csr_adv[7:0];
          s_nxt.csr_hi = csr_adv[15:8];
        end
        default: ;
      endcase
    end
    // APB read data captured in setup so it stands through the access phase
    if (apb_setup) begin
      s_nxt.prdata = rd_ok ? rd_val : '0;
      s_nxt.slverr = !rd_ok;
    end
    // APB write last so software overrides a same-cycle host byte
    if (apb_wr) begin
      if (in_blk) begin
        s_nxt.blk[blk_sel] = PWDATA[7:0];
      end else begin
        case (idx)
          lcd_pkg::IDX_DISPLAY_ENABLE_CTRL: s_nxt.disp_ctrl  = PWDATA[7:0];
          lcd_pkg::IDX_BLOCK_CURSOR_ATTR:   s_nxt.attr       = PWDATA[7:0];
          lcd_pkg::IDX_CURSOR_WIDTH:        s_nxt.csr_width  = PWDATA[7:0];
          lcd_pkg::IDX_CURSOR_HEIGHT_SHAPE: s_nxt.csr_hshape = PWDATA[7:0];
          lcd_pkg::IDX_CURSOR_SHIFT_DIR:    s_nxt.shift_dir  = PWDATA[7:0];
          lcd_pkg::IDX_CURSOR_ADDRESS_LOW:  s_nxt.csr_lo     = PWDATA[7:0];
          lcd_pkg::IDX_CURSOR_ADDRESS_HIGH: s_nxt.csr_hi     = PWDATA[7:0];
          lcd_pkg::IDX_LINE_PITCH:          s_nxt.pitch      = PWDATA[15:0];
          default: ;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_r       <= '0;
      s_r.pitch <= lcd_pkg::PITCH_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Memory write buffer; a stalled sink holds the host through HOST_READY
  lcd_wr_buffer #(
    .W ($bits(lcd_pkg::lcd_memwr_t))
  ) u_wr_buffer (
    .clk       (REF_CLK),
    .rst_n     (RSTN),
    .in_valid  (mem_push),
    .in_ready  (buf_in_ready),
    .in_data   ({csr_now, HOST_BYTE.data}),
    .out_valid (MEM_VALID),
    .out_ready (MEM_READY),
    .out_data  (MEM_WORD)
  );

  // Status outputs straight from state flops
  assign DISP_ON       = s_r.disp_ctrl[lcd_pkg::DISP_EN_BIT];
  assign BLOCK_ATTR    = s_r.attr;
  assign CURSOR_ADDR   = csr_now;
  assign CURSOR_WIDTH  = s_r.csr_width[3:0];
  assign CURSOR_HEIGHT = s_r.csr_hshape[3:0];
  assign CURSOR_BLOCK  = s_r.csr_hshape[lcd_pkg::SHAPE_BIT];
  assign SHIFT_DIR     = s_r.shift_dir[1:0];

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  logic cmd_take;
  logic par_take;
  assign cmd_take = host_take && HOST_BYTE.is_cmd;
  assign par_take = host_take && is_param;

  sequence csr_low_s;
    par_take && s_r.cmd == lcd_pkg::CURSOR_ADDRESS_LOAD_CMD && s_r.pidx == 4'h0 && !apb_wr;
  endsequence
  sequence csr_high_s;
    par_take && s_r.cmd == lcd_pkg::CURSOR_ADDRESS_LOAD_CMD && s_r.pidx == 4'h1 && !apb_wr;
  endsequence

  // R1 display off
  disp_off_a: assert property (cmd_take && HOST_BYTE.data == 8'h58 && !apb_wr |=> !DISP_ON) // R1
    else $error("display did not turn off");
  // R1 display on
  disp_on_a: assert property (cmd_take && HOST_BYTE.data == 8'h59 && !apb_wr |=> DISP_ON) // R1
    else $error("display did not turn on");
  // R2 attribute load
  attr_load_a: assert property (par_take && s_r.pidx == 4'h0 && !apb_wr &&
      (s_r.cmd == 8'h58 || s_r.cmd == 8'h59) |=> BLOCK_ATTR == $past(HOST_BYTE.data)) // R2
    else $error("attribute not loaded");
  // R3 all blocks on
  attr_all_on_a: assert property (par_take && s_r.pidx == 4'h0 && s_r.cmd == 8'h58 &&
      HOST_BYTE.data == 8'h56 && !apb_wr |=> BLOCK_ATTR.cursor_flash_field == 2'h2 &&
      BLOCK_ATTR.first_block_attr == 2'h1 && BLOCK_ATTR.second_fourth_block_attr == 2'h1 &&
      BLOCK_ATTR.third_block_attr == 2'h1) // R3
    else $error("attribute 56h fields wrong");
  // R4 two-step address load
  csr_load_a: assert property (csr_low_s ##1 csr_high_s
      |=> CURSOR_ADDR == {$past(HOST_BYTE.data), $past(HOST_BYTE.data, 2)}) // R4
    else $error("cursor address pair wrong");
  // R5 cursor width
  shape_width_a: assert property (par_take && s_r.cmd == 8'h5D && s_r.pidx == 4'h0 && !apb_wr
      |=> CURSOR_WIDTH == $past(HOST_BYTE.data[3:0])) // R5
    else $error("cursor width wrong");
  // R6 height and shape
  shape_height_a: assert property (par_take && s_r.cmd == 8'h5D && s_r.pidx == 4'h1 && !apb_wr
      |=> CURSOR_HEIGHT == $past(HOST_BYTE.data[3:0]) && CURSOR_BLOCK == $past(HOST_BYTE.data[7])) // R6
    else $error("cursor height or shape wrong");
  // R7 direction codes
  shift_dir_a: assert property (cmd_take && !apb_wr && (HOST_BYTE.data == 8'h4C || HOST_BYTE.data == 8'h4F)
      |=> SHIFT_DIR == (($past(HOST_BYTE.data) == 8'h4C) ? 2'h0 : 2'h3)) // R7
    else $error("shift direction wrong");
  // R8 write at cursor then step right
  mem_step_a: assert property (mem_push && SHIFT_DIR == 2'h0 && !apb_wr
      |=> CURSOR_ADDR == $past(CURSOR_ADDR) + 16'h0001) // R8
    else $error("cursor did not advance");
  // R10 block setup slot
  blk_load_a: assert property (par_take && s_r.cmd == 8'h44 && s_r.pidx == 4'h3 && !apb_wr
      |=> s_r.blk[3] == $past(HOST_BYTE.data)) // R10
    else $error("block setup slot wrong");
  // R11 command restarts slots
  slot_reset_a: assert property (cmd_take |=> s_r.pidx == 4'h0 ##1 1'b1) // R11
    else $error("parameter slot not reset");

endmodule : lcd_cmd_decoder
`default_nettype wire

// File: design/lcd_pkg.sv
// Purpose: Shared constants and types for the LCD command decoder.
// Assumes: Register index times four is the APB byte address.
// Notes:   Every code, index and reset value lives here, with the enable and shape bit positions.
package lcd_pkg;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] DISPLAY_SWITCH_CMD_OFF = 8'h58;
  localparam logic [7:0] DISPLAY_SWITCH_CMD_ON  = 8'h59;
  localparam logic [7:0] CURSOR_ADDRESS_LOAD_CMD = 8'h46;
  localparam logic [7:0] CURSOR_SHAPE_CMD       = 8'h5D;
  localparam logic [7:0] CURSOR_DIR_CMD_RIGHT   = 8'h4C;
  localparam logic [7:0] CURSOR_DIR_CMD_LEFT    = 8'h4D;
  localparam logic [7:0] CURSOR_DIR_CMD_UP      = 8'h4E;
  localparam logic [7:0] CURSOR_DIR_CMD_DOWN    = 8'h4F;
  localparam logic [7:0] MEMORY_WRITE_CMD       = 8'h42;
  localparam logic [7:0] BLOCK_SETUP_CMD        = 8'h44;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_DISPLAY_ENABLE_CTRL = 6'h09;
  localparam logic [5:0] IDX_BLOCK_CURSOR_ATTR   = 6'h0A;
  localparam logic [5:0] IDX_BLOCK_SETUP_FIRST   = 6'h0B;
  localparam logic [5:0] IDX_CURSOR_WIDTH        = 6'h15;
  localparam logic [5:0] IDX_CURSOR_HEIGHT_SHAPE = 6'h16;
  localparam logic [5:0] IDX_CURSOR_SHIFT_DIR    = 6'h17;
  localparam logic [5:0] IDX_CURSOR_ADDRESS_LOW  = 6'h1C;
  localparam logic [5:0] IDX_CURSOR_ADDRESS_HIGH = 6'h1D;
  localparam logic [5:0] IDX_DECODER_STATUS      = 6'h20;
  localparam logic [5:0] IDX_LINE_PITCH          = 6'h21;
  localparam int         BLOCK_SETUP_PARAMS      = 10;

  // ==========================================================================
  // Field positions, encodings and reset values
  localparam int         DISP_EN_BIT      = 0;
  localparam int         SHAPE_BIT        = 7;
  localparam logic [1:0] SHIFT_RIGHT      = 2'h0;
  localparam logic [1:0] SHIFT_LEFT       = 2'h1;
  localparam logic [1:0] SHIFT_UP         = 2'h2;
  localparam logic [1:0] SHIFT_DOWN       = 2'h3;
  localparam logic [7:0] BYTE_RESET       = 8'h00;
  localparam logic [15:0] PITCH_RESET     = 16'h0028;
  localparam logic [3:0] PIDX_LAST        = 4'hF;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic       is_cmd;
    logic [7:0] data;
  } lcd_hostbyte_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } lcd_memwr_t;

  typedef struct packed {
    logic [1:0] third_block_attr;
    logic [1:0] second_fourth_block_attr;
    logic [1:0] first_block_attr;
    logic [1:0] cursor_flash_field;
  } lcd_attr_t;

  typedef struct packed {
    logic [7:0]      disp_ctrl;
    lcd_attr_t       attr;
    logic [7:0]      csr_width;
    logic [7:0]      csr_hshape;
    logic [7:0]      shift_dir;
    logic [7:0]      csr_lo;
    logic [7:0]      csr_hi;
    logic [9:0][7:0] blk;
    logic [15:0]     pitch;
    logic [7:0]      cmd;
    logic            cmd_seen;
    logic [3:0]      pidx;
    logic [31:0]     prdata;
    logic            slverr;
  } lcd_state_t;

endpackage : lcd_pkg

// File: design/lcd_wr_buffer.sv
// Purpose: Two-entry buffer on the display memory write path.
// Assumes: Source and sink share one clock.
// Notes:   Full after two words; in_ready falls so the source stalls.
`timescale 1ns/10ps
`default_nettype none
module lcd_wr_buffer #(
  parameter int W = 24
) (
  input  wire logic         clk,       // System clock
  input  wire logic         rst_n,     // Async reset, active low
  input  wire logic         in_valid,  // Word offered
  output logic              in_ready,  // Room for a word
  input  wire logic [W-1:0] in_data,   // Word in
  output logic              out_valid, // Word available
  input  wire logic         out_ready, // Sink takes word
  output logic [W-1:0]      out_data   // Oldest word
);

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
  } lcd_buf_st_t;

  lcd_buf_st_t s_r;
  lcd_buf_st_t s_nxt;
  logic        push;
  logic        pop;

  // ==========================================================================
  // Occupancy and pointers
  assign in_ready  = (s_r.cnt != 2'h2);
  assign out_valid = (s_r.cnt != 2'h0);
  assign out_data  = s_r.mem[s_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next state; simultaneous push and pop keep the count
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp          = ~s_r.wp;
    end
    if (pop) begin
      s_nxt.rp = ~s_r.rp;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 2'h1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 2'h1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : lcd_wr_buffer
`default_nettype wire

// File: dv/lcd_cmd_decoder_tb_top.sv
// Purpose: Self-checking bench for the LCD command decoder.
// Assumes: APB answers whenever PREADY is high; memory sink stalls on demand.
// Notes:   Ordinary command rows run in one loop; stalls and reset follow.
`timescale 1ns/10ps
`default_nettype none
module lcd_cmd_decoder_tb_top;
  typedef struct {
    logic [7:0]  cmd;
    int          np;
    logic [7:0]  p1;
    logic [7:0]  p2;
    logic [35:0] exp;
  } lcd_row_t;

  logic                   REF_CLK, RSTN, HOST_VALID, HOST_READY, MEM_VALID, MEM_READY;
  lcd_pkg::lcd_hostbyte_t HOST_BYTE;
  lcd_pkg::lcd_memwr_t    MEM_WORD;
  logic                   PSEL, PENABLE, PWRITE, PREADY, PSLVERR, DISP_ON, CURSOR_BLOCK;
  logic [7:0]             PADDR;
  logic [31:0]            PWDATA, PRDATA, rd;
  lcd_pkg::lcd_attr_t     BLOCK_ATTR;
  logic [15:0]            CURSOR_ADDR;
  logic [3:0]             CURSOR_WIDTH, CURSOR_HEIGHT;
  logic [1:0]             SHIFT_DIR;
  logic                   err;
  int                     n_errors, check_count, cycles;
  lcd_pkg::lcd_memwr_t    got[$];
  lcd_row_t               rows[9];
  logic [5:0]             idx_list[7];
  logic [79:0]            blk_p;

  // ==========================================================================
  // Clock, design and host
  initial begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end

  lcd_cmd_decoder uut (.REF_CLK(REF_CLK), .RSTN(RSTN), .HOST_VALID(HOST_VALID),
    .HOST_READY(HOST_READY), .HOST_BYTE(HOST_BYTE), .MEM_VALID(MEM_VALID),
    .MEM_READY(MEM_READY), .MEM_WORD(MEM_WORD), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .DISP_ON(DISP_ON), .BLOCK_ATTR(BLOCK_ATTR), .CURSOR_ADDR(CURSOR_ADDR),
    .CURSOR_WIDTH(CURSOR_WIDTH), .CURSOR_HEIGHT(CURSOR_HEIGHT),
    .CURSOR_BLOCK(CURSOR_BLOCK), .SHIFT_DIR(SHIFT_DIR));

  lcd_host_model host (.clk(REF_CLK), .host_ready(HOST_READY), .host_valid(HOST_VALID),
    .host_byte(HOST_BYTE));

  // Memory sink records every word it accepts
  always @(posedge REF_CLK) begin
    if (RSTN === 1'b1 && MEM_VALID === 1'b1 && MEM_READY === 1'b1) got.push_back(MEM_WORD);
  end

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      conclude();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; the access is held until PREADY is seen high
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= {idx, 2'b00};
    PWDATA  <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1) @(posedge REF_CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask : apb

  function automatic logic [35:0] outs();
    return {DISP_ON, BLOCK_ATTR, CURSOR_ADDR, CURSOR_WIDTH, CURSOR_HEIGHT, CURSOR_BLOCK, SHIFT_DIR};
  endfunction : outs

  task automatic conclude();
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  // ==========================================================================
  // Main sequence
  initial begin
    RSTN = 1'b0; MEM_READY = 1'b1; PSEL = 1'b0; PENABLE = 1'b0;
    PWRITE = 1'b0; PADDR = 8'h00; PWDATA = 32'h0000_0000;
    // Row: command, parameter count, parameters, {disp,attr,addr,w,h,block,dir}
    rows = '{'{8'h58, 1, 8'h56, 8'h00, {1'b0, 8'h56, 16'h0000, 4'h0, 4'h0, 1'b0, 2'h0}},
             '{8'h46, 2, 8'h00, 8'h10, {1'b0, 8'h56, 16'h1000, 4'h0, 4'h0, 1'b0, 2'h0}},
             '{8'h5D, 2, 8'h04, 8'h86, {1'b0, 8'h56, 16'h1000, 4'h4, 4'h6, 1'b1, 2'h0}},
             '{8'h4F, 0, 8'h00, 8'h00, {1'b0, 8'h56, 16'h1000, 4'h4, 4'h6, 1'b1, 2'h3}},
             '{8'h4D, 0, 8'h00, 8'h00, {1'b0, 8'h56, 16'h1000, 4'h4, 4'h6, 1'b1, 2'h1}},
             '{8'h4E, 0, 8'h00, 8'h00, {1'b0, 8'h56, 16'h1000, 4'h4, 4'h6, 1'b1, 2'h2}},
             '{8'h4C, 0, 8'h00, 8'h00, {1'b0, 8'h56, 16'h1000, 4'h4, 4'h6, 1'b1, 2'h0}},
             '{8'h59, 0, 8'h00, 8'h00, {1'b1, 8'h56, 16'h1000, 4'h4, 4'h6, 1'b1, 2'h0}},
             '{8'h46, 2, 8'h01, 8'h10, {1'b1, 8'h56, 16'h1001, 4'h4, 4'h6, 1'b1, 2'h0}}};
    idx_list = '{6'h09, 6'h0A, 6'h15, 6'h16, 6'h17, 6'h1C, 6'h1D};
    blk_p    = 80'h00_00_40_00_10_40_00_04_00_30;
    repeat (10) @(posedge REF_CLK);
    RSTN <= 1'b1;
    @(posedge REF_CLK);
    // Listed registers read zero after reset; line pitch and decoder status do not
    foreach (idx_list[i]) begin
      apb(1'b0, idx_list[i], 32'h0000_0000);
      chk({4'h0, rd}, 36'h0); // reset register values
    end
    foreach (rows[i]) begin
      host.send(1'b1, rows[i].cmd);
      if (rows[i].np > 0) host.send(1'b0, rows[i].p1);
      if (rows[i].np > 1) host.send(1'b0, rows[i].p2);
      host.idle();
      @(posedge REF_CLK);
      chk(outs(), rows[i].exp); // outputs after row
    end
    apb(1'b0, 6'h0A, 32'h0);
    chk({4'h0, rd}, 36'h56); // attribute register
    apb(1'b0, 6'h16, 32'h0);
    chk({4'h0, rd}, 36'h86); // height and shape
    apb(1'b0, 6'h30, 32'h0);
    chk({3'h0, err, rd}, 36'h1_0000_0000); // unmapped index refused
    apb(1'b1, 6'h09, 32'h0);
    chk({35'h0, DISP_ON}, 36'h0); // enable bit by register
    // memory writes with the sink stalled until the buffer is full
    MEM_READY <= 1'b0;
    host.send(1'b1, 8'h42);
    host.send(1'b0, 8'h20);
    host.send(1'b0, 8'h00);
    host.idle();
    repeat (2) @(posedge REF_CLK);
    chk({35'h0, HOST_READY}, 36'h0); // full buffer stalls host
    MEM_READY <= 1'b1;
    host.send(1'b0, 8'h50);
    host.send(1'b1, 8'h4F);
    host.send(1'b1, 8'h42);
    host.send(1'b0, 8'hFF);
    host.idle();
    repeat (4) @(posedge REF_CLK);
    chk(36'(got.size()), 36'd4); // one word per parameter
    if (got.size() == 4) begin
      chk({12'h0, got[0]}, {12'h0, 16'h1001, 8'h20}); // word at cursor
      chk({12'h0, got[1]}, {12'h0, 16'h1002, 8'h00}); // right step
      chk({12'h0, got[2]}, {12'h0, 16'h1003, 8'h50}); // no word lost
      chk({12'h0, got[3]}, {12'h0, 16'h1004, 8'hFF}); // after direction change
    end
    chk({20'h0, CURSOR_ADDR}, {20'h0, 16'h1004 + lcd_pkg::PITCH_RESET}); // down step
    // Block setup: ten parameters fill successive slots
    host.send(1'b1, 8'h44);
    for (int k = 9; k >= 0; k--) host.send(1'b0, blk_p[k*8 +: 8]);
    host.idle();
    apb(1'b0, 6'h0F, 32'h0);
    chk({4'h0, rd}, 36'h10); // second block start high byte
    // Second reset in mid-run clears status and bus outputs; HOST_READY and PREADY stay high
    RSTN <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    chk(outs(), 36'h0); // reset outputs
    chk({3'h0, PSLVERR, PRDATA}, 36'h0); // reset bus outputs
    chk({33'h0, HOST_READY, MEM_VALID, PREADY}, 36'h5); // reset handshakes
    // Commands are taken again right after release
    RSTN <= 1'b1;
    @(posedge REF_CLK);
    host.send(1'b1, 8'h59);
    host.idle();
    @(posedge REF_CLK);
    chk({35'h0, DISP_ON}, 36'h1); // display on after reset
    conclude();
  end
endmodule : lcd_cmd_decoder_tb_top
`default_nettype wire

// File: dv/lcd_host_model.sv
// Purpose: Host CPU model that offers command and parameter bytes.
// Assumes: Tasks are called right after a rising edge of clk.
// Notes:   A released byte line shows inverted data, never the old byte.
`timescale 1ns/10ps
`default_nettype none
module lcd_host_model (
  input  wire logic              clk,        // System clock
  input  wire logic              host_ready, // Decoder takes a byte
  output logic                   host_valid, // Byte offered
  output lcd_pkg::lcd_hostbyte_t host_byte   // Command flag and byte
);
  // ==========================================================================
  // Byte handshake
  initial begin
    host_valid = 1'b0;
    host_byte  = '0;
  end

  // host marks bytes
  // Held until taken; valid stays high so bytes can go back to back
  task automatic send(input logic is_cmd, input logic [7:0] data);
    host_valid <= 1'b1;
    host_byte  <= '{is_cmd: is_cmd, data: data};
    @(posedge clk);
    while (host_ready !== 1'b1) @(posedge clk);
  endtask : send

  // Release the line; data is scrambled so nothing stale looks valid
  task automatic idle();
    host_valid <= 1'b0;
    host_byte  <= lcd_pkg::lcd_hostbyte_t'(~host_byte);
    @(posedge clk);
  endtask : idle
endmodule : lcd_host_model
`default_nettype wire
